// ### bench/ccd_checker.sv
// Port-level assertions for the clear, call and decrement executor
`timescale 1ns/10ps

module ccd_checker (
    input wire        clk_in,        // Core clock
    input wire        nrst_in,       // Reset, active low
    input wire        s_axi_awready, // Write address ready
    input wire        s_axi_wready,  // Write data ready
    input wire        s_axi_bvalid,  // Write response valid
    input wire        s_axi_bready,  // Write response ready
    input wire [7:0]  s_axi_araddr,  // Read address
    input wire        s_axi_arvalid, // Read address valid
    input wire        s_axi_arready, // Read address ready
    input wire [31:0] s_axi_rdata,   // Read data
    input wire [1:0]  s_axi_rresp,   // Read response
    input wire        s_axi_rvalid,  // Read data valid
    input wire        s_axi_rready,  // Read data ready
    input wire        busy_out,      // Instruction in progress
    input wire        done_out       // Completion pulse
);
    // ----------------------------------------------------------------
    // Instruction timing
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_done_pulse: assert property (done_out |=> !done_out)
        else $error("done held longer than one cycle");
    a_done_after_busy: assert property (done_out |-> !busy_out && $past(busy_out))
        else $error("done without a preceding busy cycle");
    a_busy_length: assert property ($rose(busy_out) |-> ##[1:2] !busy_out)
        else $error("instruction ran longer than two cycles");
    a_busy_start: assert property ($rose(busy_out) |-> $rose(s_axi_bvalid))
        else $error("instruction started without a write answer");

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready while a response is pending");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_ar_ready: assert property (s_axi_arready != s_axi_rvalid)
        else $error("read address ready does not follow read valid");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered in the next cycle");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");

    // Main scenarios reached
    c_two_cycle: cover property ($rose(busy_out) ##1 busy_out ##1 !busy_out);
    c_done: cover property (done_out);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// ### bench/tb.sv
// Self-checking bench for the clear, call and decrement executor
`timescale 1ns/10ps
`include "ccd_consts.vh"

module tb;
    reg         clk_in = 1'b0;
    reg         nrst_in = 1'b0;
    reg  [7:0]  aw_addr = 8'h00;
    reg  [7:0]  ar_addr = 8'h00;
    reg  [31:0] w_data = 32'h0;
    reg         aw_vld = 1'b0;
    reg         w_vld = 1'b0;
    reg         ar_vld = 1'b0;
    wire        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, busy, done;
    wire [1:0]  b_resp, r_resp;
    wire [31:0] r_data;
    reg  [31:0] rdv, rv, seed;
    reg  [1:0]  rsp;
    reg  [14:0] p, e_pc;
    reg  [7:0]  v, a, r, e_acc, e_fv;
    reg  [6:0]  f, l;
    reg  [2:0]  op, s;
    reg         dd, e_z, e_tmo, e_pwr, e_sk;
    integer     fails, check_count, i, cyc, e_cyc;

    always #5 clk_in = ~clk_in;

    ccd_core dut (
        .clk_in(clk_in), .nrst_in(nrst_in),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_data), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(1'b1),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld), .s_axi_rready(1'b1),
        .busy_out(busy), .done_out(done)
    );

    // ----------------------------------------------------------------
    // Comparison and closing report
    // ----------------------------------------------------------------
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task end_sim;
        begin
            $display("comparisons %0d, mismatches %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task tmo;
        begin
            fails = fails + 1;
            end_sim;
        end
    endtask

    // ----------------------------------------------------------------
    // Bus cycles: response ready is held high throughout
    // ----------------------------------------------------------------
    task wr(input [7:0] ad, input [31:0] d);
        integer n;
        reg     go;
        begin
            aw_addr <= ad;
            w_data <= d;
            aw_vld <= 1'b1;
            w_vld <= 1'b1;
            go = 1'b1;
            for (n = 0; n < 50 && go; n = n + 1) begin
                @(posedge clk_in);
                if (aw_rdy) aw_vld <= 1'b0;
                if (w_rdy) w_vld <= 1'b0;
                if (b_vld) go = 1'b0;
                rsp = b_resp;
            end
            if (go) tmo;
        end
    endtask

    task rd(input [7:0] ad);
        integer n;
        reg     go;
        begin
            ar_addr <= ad;
            ar_vld <= 1'b1;
            go = 1'b1;
            for (n = 0; n < 50 && go; n = n + 1) begin
                @(posedge clk_in);
                if (ar_rdy) ar_vld <= 1'b0;
                if (r_vld) go = 1'b0;
                rdv = r_data;
                rsp = r_resp;
            end
            if (go) tmo;
        end
    endtask

    // Start one instruction and count cycles from its answer to done
    task ex;
        begin
            wr(`CCD_ADDR_EXEC, {21'h0, op, dd, f});
            cyc = 0;
            while (done !== 1'b1 && cyc < 20) begin
                @(posedge clk_in);
                cyc = cyc + 1;
            end
            if (cyc == 20) tmo;
        end
    endtask

    // Expected result of a complement or decrement of one value
    function [7:0] result(input [2:0] o, input [7:0] x);
        result = (o == `CCD_OP_COMPL) ? ~x : x - 8'h01;
    endfunction

    // ----------------------------------------------------------------
    // Main sequence: reset values, refusals, then corner and random ops
    // ----------------------------------------------------------------
    initial begin
        fails = 0;
        check_count = 0;
        seed = 32'hf747;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        rd(`CCD_ADDR_STATUS);
        chk(rdv[4:0], 5'h06);
        rd(`CCD_ADDR_PC);
        chk(rdv[14:0], 15'h0);
        rd(8'h40);
        chk(rsp, 2'h2);
        chk(rdv, 32'h0);
        wr(8'h40, 32'h0);
        chk(rsp, 2'h2);
        for (i = 0; i < 60; i = i + 1) begin
            rv = $random(seed);
            f = rv[6:0];
            dd = rv[7];
            a = rv[15:8];
            l = rv[22:16];
            s = rv[25:23];
            rv = $random(seed);
            p = rv[14:0];
            v = (i < 7) ? 8'h01 : (i < 14) ? 8'h00 : (i < 21) ? 8'hff : rv[23:16];
            op = 3'(((i < 21) ? i : rv[31:24]) % 8);
            wr(`CCD_ADDR_FADDR, {25'h0, f});
            wr(`CCD_ADDR_FDATA, {24'h0, v});
            wr(`CCD_ADDR_ACC, {24'h0, a});
            wr(`CCD_ADDR_PC_HIGH, {25'h0, l});
            wr(`CCD_ADDR_PC, {17'h0, p});
            wr(`CCD_ADDR_STATUS, {29'h0, s});
            r = result(op, v);
            {e_acc, e_fv, e_pwr, e_tmo, e_z, e_sk} = {a, v, s, 1'b0};
            e_pc = p + 15'h1;
            e_cyc = 1;
            case (op)
                `CCD_OP_WDOG_CLR: {e_pwr, e_tmo} = 2'h3;
                `CCD_OP_NOP: ;
                `CCD_OP_CALL_ACC: begin
                    e_pc = {l, a};
                    e_cyc = 2;
                end
                `CCD_OP_CLR_REG: {e_fv, e_z} = {8'h00, 1'b1};
                `CCD_OP_CLR_ACC: {e_acc, e_z} = {8'h00, 1'b1};
                default: begin
                    if (dd) e_fv = r;
                    else e_acc = r;
                    if (op != `CCD_OP_DEC_SKIP) e_z = (r == 8'h00);
                    else if (r == 8'h00) {e_pc, e_cyc, e_sk} = {p + 15'h2, 32'd2, 1'b1};
                end
            endcase
            ex;
            chk(cyc, e_cyc);
            if (op == `CCD_OP_WDOG_CLR) begin
                rd(`CCD_ADDR_WDOG);
                chk({rdv[7:0], rdv[15:8] < 8'h10}, 9'h001);
            end
            if (op == `CCD_OP_CALL_ACC) begin
                rd(`CCD_ADDR_STACK);
                chk(rdv[14:0], p + 15'h1);
            end
            rd(`CCD_ADDR_FDATA);
            chk(rdv[7:0], e_fv);
            rd(`CCD_ADDR_ACC);
            chk(rdv[7:0], e_acc);
            rd(`CCD_ADDR_STATUS);
            chk(rdv[4:0], {e_sk, 1'b0, e_pwr, e_tmo, e_z});
            rd(`CCD_ADDR_PC);
            chk(rdv[14:0], e_pc);
        end
        end_sim;
    end
endmodule

bind ccd_core ccd_checker u_chk (
    .clk_in, .nrst_in, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .busy_out, .done_out
);

// ### rtl/ccd_consts.vh
// Constants for the clear, call and decrement instruction executor
// How it works
// - Clearing the watchdog sets its counter and its prescaler back to zero.
// - Clearing the watchdog also sets the timeout flag and the power-down flag to one.
// - A call through the accumulator first pushes the current PC plus one onto the stack.
// - The call then loads the accumulator into PC 7..0 and the high latch 6..0 into PC 14..8.
// - The call through the accumulator takes two cycles and, of the status flags, only clears the skipped bit.
// - Complement inverts every bit of file register 0..127 and updates the zero flag.
// - A destination bit of zero sends the result to the accumulator, one to the file register.
// - Clear register writes zero to the file register and always sets the zero flag.
// - Clear accumulator writes zero to the accumulator and sets the zero flag.
// - Decrement subtracts one, routes the result to its destination and updates zero.
// - Decrement and skip subtracts one, writes its destination and leaves the zero, timeout and power-down flags alone.
// - A zero result of decrement and skip discards the next instruction and spends one NOP cycle, two cycles in all.
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CCD_ADDR_EXEC     8'h00
`define CCD_ADDR_STATUS   8'h04
`define CCD_ADDR_ACC      8'h08
`define CCD_ADDR_PC       8'h0c
`define CCD_ADDR_PC_HIGH  8'h10
`define CCD_ADDR_FADDR    8'h14
`define CCD_ADDR_FDATA    8'h18
`define CCD_ADDR_STACK    8'h1c
`define CCD_ADDR_WDOG     8'h20

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define CCD_EXEC_F_LSB    0
`define CCD_EXEC_F_MSB    6
`define CCD_EXEC_D_BIT    7
`define CCD_EXEC_OP_LSB   8
`define CCD_EXEC_OP_MSB   10

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define CCD_OP_WDOG_CLR   3'h0
`define CCD_OP_CALL_ACC   3'h1
`define CCD_OP_COMPL      3'h2
`define CCD_OP_CLR_REG    3'h3
`define CCD_OP_CLR_ACC    3'h4
`define CCD_OP_DEC        3'h5
`define CCD_OP_DEC_SKIP   3'h6
`define CCD_OP_NOP        3'h7

// ----------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------
`define CCD_ST_ZERO       0
`define CCD_ST_TIMEOUT    1
`define CCD_ST_PWRDN      2
`define CCD_ST_BUSY       3
`define CCD_ST_SKIPPED    4
`define CCD_ZERO_RST      1'b0
`define CCD_TIMEOUT_RST   1'b1
`define CCD_PWRDN_RST     1'b1
`define CCD_ACC_RST       8'h00
`define CCD_PC_RST        15'h0000
`define CCD_PC_HIGH_RST   7'h00
`define CCD_FADDR_RST     7'h00
`define CCD_WDOG_CLR_VAL  8'h00
`define CCD_PRESC_CLR_VAL 8'h00

// ----------------------------------------------------------------
// Bus responses and geometry
// ----------------------------------------------------------------
`define CCD_RESP_OKAY     2'b00
`define CCD_RESP_SLVERR   2'b10
`define CCD_FILE_DEPTH    128
`define CCD_STACK_DEPTH   16

`endif

// ### rtl/ccd_core.v
// Clear, call and decrement instruction executor with an AXI4-Lite slave
`timescale 1ns/10ps
`include "ccd_consts.vh"

module ccd_core (
    input  wire        clk_in,          // Core clock, 100 MHz
    input  wire        nrst_in,         // Asynchronous reset, active low
    input  wire [7:0]  s_axi_awaddr,    // Write address
    input  wire        s_axi_awvalid,   // Write address valid
    output wire        s_axi_awready,   // Write address ready
    input  wire [31:0] s_axi_wdata,     // Write data
    input  wire [3:0]  s_axi_wstrb,     // Write byte strobes
    input  wire        s_axi_wvalid,    // Write data valid
    output wire        s_axi_wready,    // Write data ready
    output reg  [1:0]  s_axi_bresp,     // Write response
    output reg         s_axi_bvalid,    // Write response valid
    input  wire        s_axi_bready,    // Write response ready
    input  wire [7:0]  s_axi_araddr,    // Read address
    input  wire        s_axi_arvalid,   // Read address valid
    output wire        s_axi_arready,   // Read address ready
    output reg  [31:0] s_axi_rdata,     // Read data
    output reg  [1:0]  s_axi_rresp,     // Read response
    output reg         s_axi_rvalid,    // Read data valid
    input  wire        s_axi_rready,    // Read data ready
    output wire        busy_out,        // Instruction in progress
    output reg         done_out         // One-cycle pulse at completion
);

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    localparam S_IDLE  = 2'b00;
    localparam S_EXEC  = 2'b01;
    localparam S_EXTRA = 2'b10;

    // Zero test shared by the zero flag updates and the skip decision
    function zero_of;
        input [7:0] v;
        begin
            zero_of = (v == 8'h00);
        end
    endfunction

    // Merges one 32-bit write into a register under byte strobes
    function [31:0] merge_strb;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer i;
        begin
            merge_strb = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_strb[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    reg  [1:0]  state_q;
    reg  [2:0]  op_q;
    reg  [6:0]  f_q;
    reg         d_q;
    reg  [7:0]  acc_q;
    reg  [14:0] pc_q;
    reg  [6:0]  pc_high_latch_q;
    reg  [6:0]  faddr_q;
    reg         zero_q;
    reg         timeout_q;
    reg         pwrdn_q;
    reg         skipped_q;
    reg  [7:0]  wdog_q;
    reg  [7:0]  presc_q;
    reg  [7:0]  file_q [0:`CCD_FILE_DEPTH-1];
    reg         aw_got_q;
    reg         w_got_q;
    reg  [7:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg  [31:0] rd_mux;
    reg         rd_hit;
    reg  [7:0]  result;
    reg         wr_hit;
    wire        wr_go;
    wire        rd_go;
    wire        idle;
    wire        in_exec;
    wire [7:0]  src;
    wire [31:0] wr_val;
    wire        file_exec_we;
    wire        acc_exec_we;
    wire        wdog_clr;
    wire        call_push;
    wire        skip_now;
    wire [14:0] stack_top;
    wire [3:0]  stack_depth;

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    // Address and data are taken independently; the write commits once
    // both are held and the previous response has been accepted
    assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
    assign wr_go         = aw_got_q & w_got_q & ~s_axi_bvalid;

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            awaddr_q     <= 8'h00;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CCD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Address decode for writes; the read-only words answer OKAY
    always @* begin
        case (awaddr_q)
            `CCD_ADDR_EXEC, `CCD_ADDR_STATUS, `CCD_ADDR_ACC, `CCD_ADDR_PC,
            `CCD_ADDR_PC_HIGH, `CCD_ADDR_FADDR, `CCD_ADDR_FDATA,
            `CCD_ADDR_STACK, `CCD_ADDR_WDOG: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_go         = s_axi_arvalid & s_axi_arready;

    // Read multiplexer, unused upper bits read as zero
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `CCD_ADDR_EXEC:   rd_mux = {20'h00000, op_q, d_q, 1'b0, f_q};
            `CCD_ADDR_STATUS: rd_mux = {27'h0000000, skipped_q, ~idle,
                                        pwrdn_q, timeout_q, zero_q};
            `CCD_ADDR_ACC:    rd_mux = {24'h000000, acc_q};
            `CCD_ADDR_PC:     rd_mux = {17'h00000, pc_q};
            `CCD_ADDR_PC_HIGH: rd_mux = {25'h0000000, pc_high_latch_q};
            `CCD_ADDR_FADDR:  rd_mux = {25'h0000000, faddr_q};
            `CCD_ADDR_FDATA:  rd_mux = {24'h000000, file_q[faddr_q]};
            `CCD_ADDR_STACK:  rd_mux = {12'h000, stack_depth, 1'b0, stack_top};
            `CCD_ADDR_WDOG:   rd_mux = {16'h0000, presc_q, wdog_q};
            default:          rd_hit = 1'b0;
        endcase
    end

    // Read data is captured at the address handshake
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `CCD_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    assign idle     = (state_q == S_IDLE);
    assign in_exec  = (state_q == S_EXEC);
    assign busy_out = ~idle;
    assign src      = file_q[f_q];
    assign wr_val   = merge_strb(32'h00000000, wdata_q, wstrb_q);

    // Result of the operation in its execute cycle
    always @* begin
        case (op_q)
            `CCD_OP_COMPL:    result = ~src;
            `CCD_OP_DEC:      result = src - 8'h01;
            `CCD_OP_DEC_SKIP: result = src - 8'h01;
            default:          result = 8'h00;
        endcase
    end

    // Destination steering by the d bit
    assign file_exec_we = in_exec & (((op_q == `CCD_OP_COMPL) | (op_q == `CCD_OP_DEC) |
                          (op_q == `CCD_OP_DEC_SKIP)) & d_q |
                          (op_q == `CCD_OP_CLR_REG));
    assign acc_exec_we  = in_exec & (((op_q == `CCD_OP_COMPL) | (op_q == `CCD_OP_DEC) |
                          (op_q == `CCD_OP_DEC_SKIP)) & ~d_q |
                          (op_q == `CCD_OP_CLR_ACC));
    assign wdog_clr     = in_exec & (op_q == `CCD_OP_WDOG_CLR);
    assign call_push    = in_exec & (op_q == `CCD_OP_CALL_ACC);
    assign skip_now     = in_exec & (op_q == `CCD_OP_DEC_SKIP) & zero_of(result);

    // File registers: executor writes while busy, software only while idle
    always @(posedge clk_in) begin
        if (file_exec_we) begin
            file_q[f_q] <= result;
        end else if (wr_go && idle && awaddr_q == `CCD_ADDR_FDATA) begin
            file_q[faddr_q] <= wstrb_q[0] ? wdata_q[7:0] : file_q[faddr_q];
        end
    end

    // Return stack, pushed with the address after the call
    ccd_stack u_stack (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .push_in   (call_push),
        .data_in   (pc_q + 15'h0001),
        .top_out   (stack_top),
        .depth_out (stack_depth)
    );

    // ----------------------------------------------------------------
    // Watchdog counter and prescaler
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            presc_q <= `CCD_PRESC_CLR_VAL;
            wdog_q  <= `CCD_WDOG_CLR_VAL;
        end else if (wdog_clr) begin
            presc_q <= `CCD_PRESC_CLR_VAL;
            wdog_q  <= `CCD_WDOG_CLR_VAL;
        end else begin
            presc_q <= presc_q + 8'h01;
            if (presc_q == 8'hff) begin
                wdog_q <= wdog_q + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer, core registers and software writes
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q   <= S_IDLE;
            op_q      <= `CCD_OP_NOP;
            f_q       <= 7'h00;
            d_q       <= 1'b0;
            acc_q     <= `CCD_ACC_RST;
            pc_q      <= `CCD_PC_RST;
            pc_high_latch_q <= `CCD_PC_HIGH_RST;
            faddr_q   <= `CCD_FADDR_RST;
            zero_q    <= `CCD_ZERO_RST;
            timeout_q <= `CCD_TIMEOUT_RST;
            pwrdn_q   <= `CCD_PWRDN_RST;
            skipped_q <= 1'b0;
            done_out  <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (acc_exec_we) begin
                acc_q <= result;
            end
            case (state_q)
                S_IDLE: begin
                    if (wr_go) begin
                        case (awaddr_q)
                            `CCD_ADDR_EXEC: begin
                                f_q     <= wr_val[`CCD_EXEC_F_MSB:`CCD_EXEC_F_LSB];
                                d_q     <= wr_val[`CCD_EXEC_D_BIT];
                                op_q    <= wr_val[`CCD_EXEC_OP_MSB:`CCD_EXEC_OP_LSB];
                                state_q <= S_EXEC;
                            end
                            `CCD_ADDR_STATUS: begin
                                zero_q    <= wr_val[`CCD_ST_ZERO];
                                timeout_q <= wr_val[`CCD_ST_TIMEOUT];
                                pwrdn_q   <= wr_val[`CCD_ST_PWRDN];
                            end
                            `CCD_ADDR_ACC:    acc_q    <= wr_val[7:0];
                            `CCD_ADDR_PC:     pc_q     <= wr_val[14:0];
                            `CCD_ADDR_PC_HIGH: pc_high_latch_q <= wr_val[6:0];
                            `CCD_ADDR_FADDR:  faddr_q  <= wr_val[6:0];
                            default: ;
                        endcase
                    end
                end
                S_EXEC: begin
                    skipped_q <= skip_now;
                    state_q   <= S_IDLE;
                    done_out  <= 1'b1;
                    pc_q      <= pc_q + 15'h0001;
                    case (op_q)
                        `CCD_OP_WDOG_CLR: begin
                            timeout_q <= 1'b1;
                            pwrdn_q   <= 1'b1;
                        end
                        `CCD_OP_CALL_ACC: begin
                            pc_q     <= {pc_high_latch_q, acc_q};
                            state_q  <= S_EXTRA;
                            done_out <= 1'b0;
                        end
                        `CCD_OP_COMPL:   zero_q <= zero_of(result);
                        `CCD_OP_CLR_REG: zero_q <= 1'b1;
                        `CCD_OP_CLR_ACC: zero_q <= 1'b1;
                        `CCD_OP_DEC:     zero_q <= zero_of(result);
                        `CCD_OP_DEC_SKIP: begin
                            // Zero, timeout and power-down untouched; a zero result spends a NOP cycle
                            if (skip_now) begin
                                pc_q     <= pc_q + 15'h0002;
                                state_q  <= S_EXTRA;
                                done_out <= 1'b0;
                            end
                        end
                        default: ;
                    endcase
                end
                S_EXTRA: begin
                    state_q  <= S_IDLE;
                    done_out <= 1'b1;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

endmodule

// ### rtl/ccd_stack.v
// Hardware return stack for the instruction executor
`timescale 1ns/10ps
`include "ccd_consts.vh"

module ccd_stack (
    input  wire        clk_in,      // Core clock
    input  wire        nrst_in,     // Asynchronous reset, active low
    input  wire        push_in,     // Push one return address
    input  wire [14:0] data_in,     // Return address to push
    output wire [14:0] top_out,     // Current top of stack
    output wire [3:0]  depth_out    // Write pointer, wraps at depth
);

    reg  [14:0] mem_q [0:`CCD_STACK_DEPTH-1];
    reg  [3:0]  ptr_q;
    wire [3:0]  top_idx;

    // ----------------------------------------------------------------
    // Pointer; overflow simply wraps and overwrites the oldest entry
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ptr_q <= 4'h0;
        end else if (push_in) begin
            ptr_q <= ptr_q + 4'h1;
        end
    end

    // Storage, no reset needed because the pointer guards it
    always @(posedge clk_in) begin
        if (push_in) begin
            mem_q[ptr_q] <= data_in;
        end
    end

    assign top_idx   = ptr_q - 4'h1;
    assign top_out   = mem_q[top_idx];
    assign depth_out = ptr_q;

endmodule
